// >>> tal_consts.svh
// Offsets, field positions and reset values of the temperature alarm block
`ifndef TAL_CONSTS_SVH
`define TAL_CONSTS_SVH
`define TAL_DEV_ADDR 7'h4C
`define TAL_ARA      7'h0C
`define TAL_R_LTEMP  8'h00
`define TAL_R_ETEMP  8'h01
`define TAL_R_STAT   8'h02
`define TAL_R_CFG    8'h03
`define TAL_R_LHI    8'h05
`define TAL_R_LLO    8'h06
`define TAL_R_EHI    8'h07
`define TAL_R_ELO    8'h08
`define TAL_W_CFG    8'h09
`define TAL_W_LHI    8'h0B
`define TAL_W_LLO    8'h0C
`define TAL_W_EHI    8'h0D
`define TAL_W_ELO    8'h0E
`define TAL_ONESHOT  8'h0F
`define TAL_ETHERM   8'h19
`define TAL_LTHERM   8'h20
`define TAL_HYST     8'h21
`define TAL_RST_LHI  8'h55
`define TAL_RST_LLO  8'h00
`define TAL_RST_EHI  8'h55
`define TAL_RST_ELO  8'h00
`define TAL_RST_ETH  8'h6C
`define TAL_RST_LTH  8'h55
`define TAL_RST_HYST 8'h0A
`define TAL_CFG_MASK 7
`define TAL_CFG_STBY 6
`define TAL_CFG_PIN6 5
`define TAL_ST_OPEN  2
`endif

// >>> tal_pkg.sv
// Types of the temperature alarm block
`default_nettype none
package tal_pkg;
   typedef enum logic [2:0] {
      ST_IDLE     = 3'b000,
      ST_ADDR     = 3'b001,
      ST_ADDR_END = 3'b010,
      ST_ACK      = 3'b011,
      ST_WR       = 3'b100,
      ST_WR_END   = 3'b101,
      ST_RD       = 3'b110,
      ST_MACK     = 3'b111
   } tal_bus_e;

   typedef struct packed {
      logic       chan;
      logic       open;
      logic [7:0] temp;
   } tal_result_s;

   typedef struct packed {
      logic [1:0] scl_sync, sda_sync;
      logic       scl_prev, sda_prev;
      tal_bus_e   st;
      logic [3:0] cnt;
      logic [7:0] sh, tx, ptr;
      logic       rw, is_ara, have_ptr, sda_oe;
      logic [7:0] cfg, lhi, llo, ehi, elo, eth, lth, hyst, ltemp, etemp, status;
      logic       alert, fail_safe_out_n_l, fail_safe_out_n_e, second_fail_safe_out_n_l, second_fail_safe_out_n_e, eval, one_tog;
      logic [1:0] req_sync;
      logic       req_seen, pin6_n, pin6_oe, fs_n, fs_oe;
   } tal_main_s;

   typedef struct packed {
      logic [1:0]  stby_sync, os_sync, ack_sync, open_sync;
      logic        os_prev, os_pend, open_cap, busy, chan, req_tog, run, start;
      tal_result_s res;
   } tal_conv_s;
endpackage
`default_nettype wire

// >>> tal_alarm.sv
// Alarm, fail-safe and bus logic of a two-channel temperature monitor
`timescale 1ns/100ps
`default_nettype none
`include "tal_consts.svh"

//////////////////////////////////////////////////////////////////////////////
module tal_alarm (
   input  wire logic       i_clock,
   input  wire logic       i_rst,
   input  wire logic       i_conv_clock,
   input  wire logic       i_scl,
   input  wire logic       i_sda,
   input  wire logic       i_conv_done,
   input  wire logic [7:0] i_conv_temp,
   input  wire logic       i_open_sensor,
   output logic            o_sda_out,
   output logic            o_sda_oe,
   output logic            o_alarm_pin_n,
   output logic            o_alarm_pin_oe,
   output logic            o_fail_safe_out_n,
   output logic            o_fail_safe_oe,
   output logic            o_conv_run,
   output logic            o_conv_start,
   output logic            o_conv_channel
);
   import tal_pkg::*;

   tal_main_s s, n;
   tal_conv_s c, nc;
   logic       scl_rise, scl_fall, bus_start, bus_stop, sda;
   logic       ara_done, st_clr, arrive;
   logic [7:0] sets, rdata;

   function automatic logic hyst_flag(input logic [7:0] t, input logic [7:0] lim,
                                      input logic [7:0] h, input logic cur);
      hyst_flag = (t > lim) | (cur & (({1'b0, t} + {1'b0, h}) > {1'b0, lim}));
   endfunction

   //////////////////////////////////////////////////////////////////////////
   // Pins pass two flops before any edge logic looks at them
   assign sda       = s.sda_sync[1];
   assign scl_rise  = s.scl_sync[1] & ~s.scl_prev;
   assign scl_fall  = ~s.scl_sync[1] & s.scl_prev;
   assign bus_start = s.scl_sync[1] & s.scl_prev & s.sda_prev & ~sda;
   assign bus_stop  = s.scl_sync[1] & s.scl_prev & ~s.sda_prev & sda;
   assign arrive    = s.req_sync[1] != s.req_seen;

   always_comb
   begin
      case (s.ptr)
         `TAL_R_LTEMP: rdata = s.ltemp;
         `TAL_R_ETEMP: rdata = s.etemp;
         `TAL_R_STAT:  rdata = s.status;
         `TAL_R_CFG:   rdata = s.cfg;
         `TAL_R_LHI:   rdata = s.lhi;
         `TAL_R_LLO:   rdata = s.llo;
         `TAL_R_EHI:   rdata = s.ehi;
         `TAL_R_ELO:   rdata = s.elo;
         `TAL_ETHERM:  rdata = s.eth;
         `TAL_LTHERM:  rdata = s.lth;
         `TAL_HYST:    rdata = s.hyst;
         default:      rdata = 8'h00;
      endcase
   end

   //////////////////////////////////////////////////////////////////////////
   // Main domain: bus slave, limits, flags and pins
   always_comb
   begin
      n          = s;
      ara_done   = 1'b0;
      st_clr     = 1'b0;
      n.scl_sync = {s.scl_sync[0], i_scl};
      n.sda_sync = {s.sda_sync[0], i_sda};
      n.scl_prev = s.scl_sync[1];
      n.sda_prev = s.sda_sync[1];
      n.eval     = 1'b0;
      // Bus slave never looks at standby, so it stays live there
      if (bus_start)
      begin
         n.st       = ST_ADDR;
         n.cnt      = 4'h0;
         n.have_ptr = 1'b0;
         n.sda_oe   = 1'b0;
      end
      else if (bus_stop)
      begin
         n.st     = ST_IDLE;
         n.sda_oe = 1'b0;
      end
      else
      begin
         case (s.st)
            ST_ADDR, ST_WR:
               if (scl_rise)
               begin
                  n.sh  = {s.sh[6:0], sda};
                  n.cnt = s.cnt + 4'h1;
                  if (s.cnt == 4'h7)
                     n.st = (s.st == ST_ADDR) ? ST_ADDR_END : ST_WR_END;
               end
            ST_ADDR_END:
               if (scl_fall)
               begin
                  n.rw     = s.sh[0];
                  // Only an active alarm answers, and only while TAL_CFG_PIN6 is clear
                  n.is_ara = (s.sh[7:1] == `TAL_ARA) & s.sh[0] & s.alert
                             & ~s.cfg[`TAL_CFG_PIN6];
                  if ((s.sh[7:1] == `TAL_DEV_ADDR) || n.is_ara)
                  begin
                     n.sda_oe = 1'b1;
                     n.st     = ST_ACK;
                  end
                  else
                     n.st = ST_IDLE;
               end
            ST_ACK:
               if (scl_fall)
               begin
                  n.cnt = 4'h0;
                  if (s.rw)
                  begin
                     n.tx     = s.is_ara ? {`TAL_DEV_ADDR, 1'b1} : rdata;
                     n.sda_oe = ~n.tx[7];
                     n.st     = ST_RD;
                     st_clr   = ~s.is_ara && (s.ptr == `TAL_R_STAT);
                  end
                  else
                  begin
                     n.sda_oe = 1'b0;
                     n.st     = ST_WR;
                  end
               end
            ST_WR_END:
               if (scl_fall)
               begin
                  n.sda_oe = 1'b1;
                  n.rw     = 1'b0;
                  n.st     = ST_ACK;
                  if (!s.have_ptr)
                  begin
                     n.ptr      = s.sh;
                     n.have_ptr = 1'b1;
                  end
                  else
                  begin
                     n.eval = 1'b1;
                     case (s.ptr)
                        `TAL_W_CFG:   n.cfg  = s.sh;
                        `TAL_W_LHI:   n.lhi  = s.sh;
                        `TAL_W_LLO:   n.llo  = s.sh;
                        `TAL_W_EHI:   n.ehi  = s.sh;
                        `TAL_W_ELO:   n.elo  = s.sh;
                        `TAL_ETHERM:  n.eth  = s.sh;
                        `TAL_LTHERM:  n.lth  = s.sh;
                        `TAL_HYST:    n.hyst = s.sh;
                        `TAL_ONESHOT: n.one_tog = ~s.one_tog;
                        default:      n.eval = 1'b0;
                     endcase
                  end
               end
            ST_RD:
               if (scl_rise)
               begin
                  n.cnt = s.cnt + 4'h1;
                  // Released a one but line is low: lost arbitration
                  if (s.tx[7] & ~sda)
                  begin
                     n.st     = ST_IDLE;
                     n.sda_oe = 1'b0;
                  end
               end
               else if (scl_fall)
               begin
                  if (s.cnt == 4'h8)
                  begin
                     n.sda_oe = 1'b0;
                     n.st     = ST_MACK;
                     ara_done = s.is_ara;
                  end
                  else
                  begin
                     n.tx     = {s.tx[6:0], 1'b0};
                     n.sda_oe = ~s.tx[6];
                  end
               end
            ST_MACK:
               if (scl_rise)
                  n.st = ST_IDLE;
            ST_IDLE:
               n.sda_oe = 1'b0;
            default:
               n.st = ST_IDLE;
         endcase
      end

      // Results arrive through a toggle; data is held until echoed back
      n.req_sync = {s.req_sync[0], c.req_tog};
      if (arrive)
      begin
         n.req_seen = s.req_sync[1];
         n.eval     = 1'b1;
         if (c.res.chan)
            n.etemp = c.res.temp;
         else
            n.ltemp = c.res.temp;
      end
      sets = 8'h00;
      if (s.eval)
         sets = {1'b0, s.ltemp > s.lhi, s.ltemp <= s.llo, s.etemp > s.ehi,
                 s.etemp <= s.elo, 1'b0, s.fail_safe_out_n_e, s.fail_safe_out_n_l};
      sets[`TAL_ST_OPEN] = arrive & c.res.open;
      // A flag raised in the cycle of a status read survives it
      n.status = (st_clr ? 8'h00 : s.status) | sets;

      // Sticky alarm: needs the alert read, a clean status and no cause
      if ((|n.status[6:0]) & ~s.cfg[`TAL_CFG_MASK] & ~s.cfg[`TAL_CFG_PIN6])
         n.alert = 1'b1;
      else if (ara_done && (s.status[6:0] == 7'h00))
         n.alert = 1'b0;

      n.fail_safe_out_n_l  = hyst_flag(s.ltemp, s.lth, s.hyst, s.fail_safe_out_n_l);
      n.fail_safe_out_n_e  = hyst_flag(s.etemp, s.eth, s.hyst, s.fail_safe_out_n_e);
      n.second_fail_safe_out_n_l = hyst_flag(s.ltemp, s.lhi, s.hyst, s.second_fail_safe_out_n_l);
      n.second_fail_safe_out_n_e = hyst_flag(s.etemp, s.ehi, s.hyst, s.second_fail_safe_out_n_e);
      n.fs_n     = ~(s.fail_safe_out_n_l | s.fail_safe_out_n_e);
      n.fs_oe    = s.fail_safe_out_n_l | s.fail_safe_out_n_e;
      n.pin6_n   = s.cfg[`TAL_CFG_PIN6] ? ~(s.second_fail_safe_out_n_l | s.second_fail_safe_out_n_e) : ~s.alert;
      n.pin6_oe  = ~n.pin6_n;
   end

   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         s          <= '0;
         s.scl_sync <= 2'h3;
         s.sda_sync <= 2'h3;
         s.scl_prev <= 1'b1;
         s.sda_prev <= 1'b1;
         s.lhi      <= `TAL_RST_LHI;
         s.llo      <= `TAL_RST_LLO;
         s.ehi      <= `TAL_RST_EHI;
         s.elo      <= `TAL_RST_ELO;
         s.eth      <= `TAL_RST_ETH;
         s.lth      <= `TAL_RST_LTH;
         s.hyst     <= `TAL_RST_HYST;
         s.fs_n     <= 1'b1;
         s.pin6_n   <= 1'b1;
      end
      else
         s <= n;
   end

   //////////////////////////////////////////////////////////////////////////
   // Conversion domain: paces the converter, samples the open comparator
   always_comb
   begin
      nc           = c;
      nc.stby_sync = {c.stby_sync[0], s.cfg[`TAL_CFG_STBY]};
      nc.os_sync   = {c.os_sync[0], s.one_tog};
      nc.ack_sync  = {c.ack_sync[0], s.req_seen};
      nc.open_sync = {c.open_sync[0], i_open_sensor};
      nc.os_prev   = c.os_sync[1];
      nc.start     = 1'b0;
      nc.run       = ~c.stby_sync[1] | c.os_pend;
      if (c.busy & ~c.run)
         nc.busy = 1'b0; // Aborted, result dropped
      else if (c.busy & i_conv_done)
      begin
         nc.res     = '{chan: c.chan, open: c.open_cap, temp: i_conv_temp};
         nc.req_tog = ~c.req_tog;
         nc.busy    = 1'b0;
         nc.chan    = ~c.chan;
         if (c.chan)
            nc.os_pend = 1'b0; // Back to standby after both channels
      end
      else if (~c.busy & c.run & (c.ack_sync[1] == c.req_tog))
      begin
         nc.start    = 1'b1;
         nc.busy     = 1'b1;
         nc.open_cap = c.open_sync[1];
      end
      if (c.os_sync[1] ^ c.os_prev)
      begin
         nc.os_pend = 1'b1;
         if (~c.busy)
            nc.chan = 1'b0;
      end
   end

   always_ff @(posedge i_conv_clock or posedge i_rst)
   begin
      if (i_rst)
         c <= '0;
      else
         c <= nc;
   end

   assign o_sda_out         = 1'b0;
   assign o_sda_oe          = s.sda_oe;
   assign o_alarm_pin_n     = s.pin6_n;
   assign o_alarm_pin_oe    = s.pin6_oe;
   assign o_fail_safe_out_n = s.fs_n;
   assign o_fail_safe_oe    = s.fs_oe;
   assign o_conv_run        = c.run;
   assign o_conv_start      = c.start;
   assign o_conv_channel    = c.chan;

   //////////////////////////////////////////////////////////////////////////
   // Checks
   alarm_pin_low_a: assert property (@(posedge i_clock) disable iff (i_rst)
      s.alert && !s.cfg[`TAL_CFG_PIN6] |=> !o_alarm_pin_n && o_alarm_pin_oe)
      else $error("alarm pin not pulled low");
   alarm_hold_a: assert property (@(posedge i_clock) disable iff (i_rst)
      s.alert && (s.status[6:0] != 7'h00) |=> s.alert)
      else $error("alarm released with status set");
   ara_answer_a: assert property (@(posedge i_clock) disable iff (i_rst)
      s.st == ST_ACK && scl_fall && s.rw && s.is_ara
      |=> s.tx == {`TAL_DEV_ADDR, 1'b1} && s.st == ST_RD)
      else $error("wrong alert answer");
   fs_assert_a: assert property (@(posedge i_clock) disable iff (i_rst)
      (s.ltemp > s.lth)[*2] |=> !o_fail_safe_out_n && o_fail_safe_oe)
      else $error("fail-safe not asserted");
   fs_hyst_a: assert property (@(posedge i_clock) disable iff (i_rst)
      s.fail_safe_out_n_e && (({1'b0, s.etemp} + {1'b0, s.hyst}) > {1'b0, s.eth}) |=> s.fail_safe_out_n_e)
      else $error("fail-safe released inside hysteresis");
   open_flag_a: assert property (@(posedge i_clock) disable iff (i_rst)
      arrive && c.res.open |=> s.status[`TAL_ST_OPEN])
      else $error("open flag not set");
   oneshot_tog_a: assert property (@(posedge i_clock) disable iff (i_rst)
      s.st == ST_WR_END && scl_fall && s.have_ptr && s.ptr == `TAL_ONESHOT
      |=> s.one_tog != $past(s.one_tog))
      else $error("one-shot write lost");
   standby_stop_a: assert property (@(posedge i_conv_clock) disable iff (i_rst)
      c.stby_sync[1] && !c.os_pend |=> !o_conv_run ##1 !c.busy)
      else $error("converter runs in standby");
   cover_ara_c: cover property (@(posedge i_clock) disable iff (i_rst) ara_done);
   cover_fs_c: cover property (@(posedge i_clock) disable iff (i_rst) $fell(o_fail_safe_out_n));
   cover_os_c: cover property (@(posedge i_conv_clock) disable iff (i_rst)
      c.stby_sync[1] && c.os_pend && c.start);
endmodule
`default_nettype wire

// >>> tal_host.sv
// SMBus host model that masters register and alert transfers
`timescale 1ns/100ps
`default_nettype none
`include "tal_consts.svh"
module tal_host (
   input  wire logic i_clock,
   input  wire logic i_sda,
   output var logic  o_scl,
   output var logic  o_sda_low
);
   localparam int HALF = 6; // Above the 4-cycle phase minimum
   initial
   begin
      o_scl = 1'b1;
      o_sda_low = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic gap(input int n);
      repeat (n) @(negedge i_clock);
   endtask
   // Data moves a little after the fall, never while SCL is high
   task automatic bit_io(input logic b, output logic r);
      gap(2);
      o_sda_low = ~b;
      gap(HALF);
      o_scl = 1'b1;
      gap(HALF);
      r = i_sda;
      o_scl = 1'b0;
   endtask
   task automatic start_c();
      o_sda_low = 1'b1;
      gap(HALF);
      o_scl = 1'b0;
   endtask
   task automatic stop_c();
      gap(2);
      o_sda_low = 1'b1;
      gap(HALF);
      o_scl = 1'b1;
      gap(HALF);
      o_sda_low = 1'b0;
      gap(HALF);
   endtask
   task automatic tx(input logic [7:0] b, inout logic ok);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_io(b[i], r);
      bit_io(1'b1, r);
      ok = ok & ~r;
   endtask
   // One byte, then no-acknowledge
   task automatic rx(output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_io(1'b1, d[i]);
      bit_io(1'b1, r);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic wr(input logic [7:0] p, input logic [7:0] d, input bit wd, output logic ok);
      ok = 1'b1;
      start_c();
      tx({`TAL_DEV_ADDR, 1'b0}, ok);
      tx(p, ok);
      if (wd)
         tx(d, ok);
      stop_c();
   endtask
   task automatic rd(input logic [7:0] p, output logic [7:0] d, output logic ok);
      wr(p, 8'h00, 1'b0, ok);
      start_c();
      tx({`TAL_DEV_ADDR, 1'b1}, ok);
      rx(d);
      stop_c();
   endtask
   // Zeros in w imitate a rival device answering the same alert read
   task automatic ara(input logic [7:0] w, output logic [7:0] d, output logic ok);
      logic r;
      ok = 1'b1;
      start_c();
      tx({`TAL_ARA, 1'b1}, ok);
      d = 8'hFF;
      if (ok)
      begin
         for (int i = 7; i >= 0; i--)
            bit_io(w[i], d[i]);
         bit_io(1'b1, r);
      end
      stop_c();
   endtask
endmodule
`default_nettype wire

// >>> temp_alarm_interrupt_logic_tb.sv
// Testbench of the temperature alarm block with a converter model
`timescale 1ns/100ps
`default_nettype none
`include "tal_consts.svh"
module temp_alarm_interrupt_logic_tb;
   import tal_pkg::*;
   logic       i_clock = 1'b0;
   logic       i_rst = 1'b1;
   logic       conv_clock = 1'b0;
   logic       scl, sda_low, sda_line, sda_oe, ok;
   logic       alarm_n, alarm_oe, fs_n, fs_oe, conv_run, conv_start, conv_chan;
   logic       conv_done = 1'b0;
   logic       open_sensor = 1'b0;
   logic       conv_ch = 1'b0;
   logic [7:0] conv_temp = 8'h00;
   logic [7:0] data;
   logic [7:0] temps [2];
   int         conv_left = 0;
   int         done_count = 0;
   int         cycles = 0;
   int         num_errors = 0;
   int         total_checks = 0;
   // Pull-up on the data line
   assign sda_line = ~(sda_low | sda_oe);
   always #4 i_clock = ~i_clock;
   initial
   begin
      #3;
      forever #24 conv_clock = ~conv_clock;
   end
   tal_alarm u_tal_alarm (
      .i_clock           (i_clock),
      .i_rst             (i_rst),
      .i_conv_clock      (conv_clock),
      .i_scl             (scl),
      .i_sda             (sda_line),
      .i_conv_done       (conv_done),
      .i_conv_temp       (conv_temp),
      .i_open_sensor     (open_sensor),
      .o_sda_out         (),
      .o_sda_oe          (sda_oe),
      .o_alarm_pin_n     (alarm_n),
      .o_alarm_pin_oe    (alarm_oe),
      .o_fail_safe_out_n (fs_n),
      .o_fail_safe_oe    (fs_oe),
      .o_conv_run        (conv_run),
      .o_conv_start      (conv_start),
      .o_conv_channel    (conv_chan)
   );
   tal_host u_tal_host (
      .i_clock   (i_clock),
      .i_sda     (sda_line),
      .o_scl     (scl),
      .o_sda_low (sda_low)
   );
   ////////////////////////////////////////////////////////////////////////////////
   // Converter: reading leaves the bus outside the done pulse
   always @(negedge conv_clock)
   begin
      conv_done <= 1'b0;
      conv_temp <= ~conv_temp;
      if (conv_run !== 1'b1)
         conv_left <= 0;
      else if (conv_left == 1)
      begin
         conv_done <= 1'b1;
         conv_temp <= temps[conv_ch];
         done_count <= done_count + 1;
         conv_left <= 0;
      end
      else if (conv_left > 1)
         conv_left <= conv_left - 1;
      else if (conv_start === 1'b1)
      begin
         conv_left <= 4;
         conv_ch <= conv_chan;
      end
   end
   always @(posedge i_clock)
   begin
      cycles <= cycles + 1;
      if (cycles == 60000)
      begin
         num_errors = num_errors + 1;
         results();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic results();
      $display("checks %0d, mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      total_checks++;
      if (g !== e)
      begin
         num_errors++;
         $display("unexpected %s: expected %h, seen %h", n, e, g);
      end
   endtask
   task automatic chk1(input string n, input logic e, input logic g);
      chk(n, {7'h00, e}, {7'h00, g});
   endtask
   task automatic wait_clk(input int n);
      repeat (n) @(negedge i_clock);
   endtask
   // Bounded wait for n finished conversions
   task automatic wait_conv(input int n);
      int target;
      target = done_count + n;
      for (int k = 0; k < 3000 && done_count < target; k++)
         @(negedge i_clock);
      chk1("conversions", 1'b1, done_count >= target);
      wait_clk(20);
   endtask
   task automatic rd_chk(input string n, input logic [7:0] p, input logic [7:0] e);
      logic [7:0] d;
      u_tal_host.rd(p, d, ok);
      chk1("read ack", 1'b1, ok);
      chk(n, e, d);
   endtask
   task automatic reg_wr(input logic [7:0] p, input logic [7:0] d);
      u_tal_host.wr(p, d, 1'b1, ok);
      chk1("write ack", 1'b1, ok);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Fail-safe limits stay at defaults: local equal to its high limit, remote below it
   initial
   begin
      temps[0] = 8'h55;
      temps[1] = 8'h30;
      wait_clk(8);
      i_rst = 1'b0;
      wait_clk(4);
      chk1("alarm drive", 1'b0, alarm_oe);
      chk1("fail-safe drive", 1'b0, fs_oe);
      rd_chk("hysteresis", `TAL_HYST, 8'h0A);
      reg_wr(`TAL_HYST, 8'h05);
      rd_chk("hysteresis", `TAL_HYST, 8'h05);
      reg_wr(`TAL_HYST, 8'h0A);
      wait_conv(4);
      rd_chk("local temp", `TAL_R_LTEMP, 8'h55);
      u_tal_host.rd(`TAL_R_STAT, data, ok);
      // Zero readings at reset meet the zero low limits and latch the alarm
      u_tal_host.ara(8'hFF, data, ok);
      chk1("alert ack", 1'b1, ok);
      wait_conv(4);
      rd_chk("status", `TAL_R_STAT, 8'h00);
      chk1("alarm pin", 1'b1, alarm_n);
      $display("test defaults done");
      temps[0] = 8'h56;
      wait_conv(4);
      chk1("alarm pin", 1'b0, alarm_n);
      chk1("alarm drive", 1'b1, alarm_oe);
      chk1("fail-safe pin", 1'b0, fs_n);
      rd_chk("status", `TAL_R_STAT, 8'h41);
      u_tal_host.ara(8'hFF, data, ok);
      chk1("alert ack", 1'b1, ok);
      chk("alert address", {`TAL_DEV_ADDR, 1'b1}, data);
      chk1("alarm pin", 1'b0, alarm_n);
      temps[0] = 8'h4C;
      wait_conv(4);
      chk1("fail-safe pin", 1'b0, fs_n);
      temps[0] = 8'h4B;
      wait_conv(4);
      chk1("fail-safe pin", 1'b1, fs_n);
      u_tal_host.rd(`TAL_R_STAT, data, ok);
      // A lower address answering at once wins; this device stays pending
      u_tal_host.ara(8'h31, data, ok);
      chk("alert rival", 8'h31, data);
      chk1("alarm pin", 1'b0, alarm_n);
      for (int k = 0; k < 3 && alarm_n === 1'b0; k++)
         u_tal_host.ara(8'hFF, data, ok);
      chk1("alarm pin", 1'b1, alarm_n);
      $display("test alert done");
      reg_wr(`TAL_W_CFG, 8'h80);
      temps[1] = 8'h6D;
      wait_conv(4);
      chk1("alarm pin", 1'b1, alarm_n);
      chk1("fail-safe pin", 1'b0, fs_n);
      temps[1] = 8'h62;
      wait_conv(4);
      chk1("fail-safe pin", 1'b1, fs_n);
      reg_wr(`TAL_W_CFG, 8'hA0);
      temps[1] = 8'h56;
      wait_conv(4);
      chk1("second fail-safe", 1'b0, alarm_n);
      temps[1] = 8'h4C;
      wait_conv(4);
      chk1("second fail-safe", 1'b0, alarm_n);
      temps[1] = 8'h4B;
      wait_conv(4);
      chk1("second fail-safe", 1'b1, alarm_n);
      u_tal_host.rd(`TAL_R_STAT, data, ok);
      $display("test fail-safe done");
      reg_wr(`TAL_W_CFG, 8'h40);
      wait_clk(100);
      temps[0] = 8'h20;
      wait_clk(400);
      chk1("converter run", 1'b0, conv_run);
      rd_chk("local temp", `TAL_R_LTEMP, 8'h4B);
      reg_wr(`TAL_ONESHOT, 8'h5A);
      wait_conv(2);
      rd_chk("local temp", `TAL_R_LTEMP, 8'h20);
      chk1("converter run", 1'b0, conv_run);
      reg_wr(`TAL_W_LLO, 8'h20);
      wait_clk(20);
      chk1("alarm pin", 1'b0, alarm_n);
      $display("test standby done");
      reg_wr(`TAL_W_LLO, 8'h00);
      reg_wr(`TAL_W_CFG, 8'h00);
      u_tal_host.rd(`TAL_R_STAT, data, ok);
      u_tal_host.ara(8'hFF, data, ok);
      chk1("alarm pin", 1'b1, alarm_n);
      open_sensor = 1'b1;
      wait_conv(4);
      chk1("alarm pin", 1'b0, alarm_n);
      rd_chk("status", `TAL_R_STAT, 8'h04);
      open_sensor = 1'b0;
      $display("test open sensor done");
      results();
   end
endmodule
`default_nettype wire
